// file: src/cspsb_pkg.sv
package cspsb_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_NMI_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NMI_GATE = 8'h04;
  localparam logic [7:0] ADDR_EV_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EV_MASK = 8'h0C;
  localparam logic [7:0] ADDR_SMI_EN = 8'h10;
  localparam logic [7:0] ADDR_SMI_PEND = 8'h14;
  localparam logic [7:0] ADDR_SMI_SW = 8'h18;
  localparam logic [7:0] ADDR_STOP_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NMI_SERR_STS = 0;
  localparam int NMI_CHK_STS = 1;
  localparam int NMI_SERR_DIS = 2;
  localparam int NMI_CHK_DIS = 3;
  localparam int EV_NMI = 0;
  localparam int EV_SMI = 1;
  localparam int EV_STOP = 2;
  localparam int EV_SLEEP = 3;
  localparam int EV_W = 4;
  localparam int SMI_HW_W = 3;
  localparam int SMI_SW_BIT = 3;
  localparam int SMI_W = 4;
  localparam int STOP_SW = 0;
  localparam int STOP_SLEEP = 1;
  localparam int STOP_HW_EN = 2;
  localparam int PIN_NMI = 0;
  localparam int PIN_SMI = 1;
  localparam int PIN_STOP = 2;
  localparam int PIN_SLEEP = 3;
  localparam int PIN_STATE = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] NMI_DIS_RST = 2'h0;
  localparam logic NMI_GATE_RST = 1'b1;
  localparam logic [3:0] EV_MASK_RST = 4'h0;
  localparam logic [2:0] SMI_EN_RST = 3'h0;
  localparam logic [2:0] STOP_CTRL_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } cspsb_req_type;

  typedef struct packed {
    logic level;
    logic oe_n;
  } cspsb_od_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STOP = 2'h1,
    ST_SLEEP = 2'h3,
    ST_WAKE = 2'h2
  } cspsb_stop_state_type;

endpackage

// file: src/cspsb_sticky.sv
`timescale 1ns/100ps
`default_nettype none

module cspsb_sticky #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Held flags
  output logic [W-1:0] flag
);

  typedef struct packed {
    logic [W-1:0] flag;
  } cspsb_sticky_state_type;

  cspsb_sticky_state_type state;
  cspsb_sticky_state_type next_state;

  // Set wins, so an event in the clear cycle is never lost
  always_comb begin
    next_state = state;
    next_state.flag = (state.flag & ~clr) | set;
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule

`default_nettype wire

// file: src/cspsb_od_pin.sv
`timescale 1ns/100ps
`default_nettype none

module cspsb_od_pin (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control
  input wire logic assert_req,
  input wire logic hold_off,
  // Pin drive
  output cspsb_pkg::cspsb_od_type pin
);

  typedef struct packed {
    cspsb_pkg::cspsb_od_type pin;
  } cspsb_od_state_type;

  cspsb_od_state_type state;
  cspsb_od_state_type next_state;

  // Only ever pull low; suspend floats the pin
  always_comb begin
    next_state = state;
    next_state.pin.level = 1'b0;
    next_state.pin.oe_n = hold_off | ~assert_req;
  end

  // Reset floats the pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{pin: '{level: 1'b0, oe_n: 1'b1}};
    end else begin
      state <= next_state;
    end
  end

  assign pin = state.pin;

endmodule

`default_nettype wire

// file: src/cspsb_top.sv
// What this block does
// - Raise nmi when system error or channel check occurs and is enabled.
// - Setting a source disable bit clears its condition and output.
// - nmi is allowed only while the gate bit is zero.
// - nmi is low in reset, after reset and in suspend.
// - Sleep request pulls low on demand; floats in reset and suspend.
// - Management interrupt pulls low on enabled events and software requests; floats otherwise.
// - Clock-stop request pulls low on events, clocked; floats in reset.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module cspsb_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register port
  input wire cspsb_pkg::cspsb_req_type reg_req,
  output logic [31:0] reg_rdata,
  // Interrupt sources, active low
  input wire logic pci_serr_n,
  input wire logic isa_chk_n,
  // Management and clock-stop event sources
  input wire logic [2:0] smi_event,
  input wire logic stop_event,
  // Power-on suspend
  input wire logic pos_suspend,
  // Processor sideband pins
  output logic nmi,
  input wire logic system_mgmt_interrupt_n_in,
  output cspsb_pkg::cspsb_od_type system_mgmt_interrupt_n,
  input wire logic cpu_clock_stop_request_n_in,
  output cspsb_pkg::cspsb_od_type cpu_clock_stop_request_n,
  input wire logic cpu_sleep_request_n_in,
  output cspsb_pkg::cspsb_od_type cpu_sleep_request_n,
  // Interrupt to the local processor
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] nmi_dis;
    logic nmi_gate;
    logic [3:0] ev_mask;
    logic [2:0] smi_en;
    logic [2:0] stop_ctrl;
    cspsb_pkg::cspsb_stop_state_type stop_state;
    logic nmi;
    logic irq;
    logic smi_prev;
    logic [31:0] rdata;
  } cspsb_top_state_type;

  cspsb_top_state_type state;
  cspsb_top_state_type next_state;

  logic [1:0] nmi_src;
  logic [1:0] nmi_sts;
  logic [1:0] nmi_set;
  logic [1:0] nmi_clr;
  logic [3:0] ev_sts;
  logic [3:0] ev_set;
  logic [3:0] ev_clr;
  logic [3:0] smi_pend;
  logic [3:0] smi_set;
  logic [3:0] smi_clr;
  logic wr_nmi;
  logic wr_ev;
  logic wr_smi;
  logic wr_sw;
  logic stop_req;
  logic sleep_req;
  logic stop_on;
  logic sleep_on;
  logic next_nmi;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Writes to status registers clear by writing one
  assign wr_nmi = reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_NMI_CTRL;
  assign wr_ev = reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_EV_STATUS;
  assign wr_smi = reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_SMI_PEND;
  assign wr_sw = reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_SMI_SW;

  // ----------------------------------------------------------------
  // Nonmaskable interrupt sources
  // ----------------------------------------------------------------
  // Sources latch only while enabled; a disabled source is held clear
  assign nmi_src = {~isa_chk_n, ~pci_serr_n};
  assign nmi_set = nmi_src & ~state.nmi_dis;
  always_comb begin
    nmi_clr = state.nmi_dis;
    if (wr_nmi) begin
      nmi_clr = nmi_clr | reg_req.wdata[cspsb_pkg::NMI_CHK_STS:
                                        cspsb_pkg::NMI_SERR_STS];
    end
  end

  cspsb_sticky #(
    .W(2)
  ) u_nmi_sts (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set(nmi_set),
    .clr(nmi_clr),
    .flag(nmi_sts)
  );

  // Level output; a new request after a clear gives a fresh rising edge
  assign next_nmi = ~pos_suspend & ~state.nmi_gate
                    & |(nmi_sts & ~state.nmi_dis);

  // ----------------------------------------------------------------
  // System management interrupt sources
  // ----------------------------------------------------------------
  // Hardware events latch when enabled; one software bit on top
  always_comb begin
    smi_set = '0;
    smi_set[cspsb_pkg::SMI_HW_W-1:0] = smi_event & state.smi_en;
    smi_set[cspsb_pkg::SMI_SW_BIT] =
      wr_sw & reg_req.wdata[0];
    smi_clr = '0;
    if (wr_smi) begin
      smi_clr = reg_req.wdata[cspsb_pkg::SMI_W-1:0];
    end
  end

  cspsb_sticky #(
    .W(cspsb_pkg::SMI_W)
  ) u_smi_pend (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set(smi_set),
    .clr(smi_clr),
    .flag(smi_pend)
  );

  // ----------------------------------------------------------------
  // Clock-stop and sleep sequencing
  // ----------------------------------------------------------------
  // Sleep is only requested while the clock is already stopped
  assign stop_req = state.stop_ctrl[cspsb_pkg::STOP_SW]
                    | (state.stop_ctrl[cspsb_pkg::STOP_HW_EN] & stop_event);
  assign sleep_req = stop_req & state.stop_ctrl[cspsb_pkg::STOP_SLEEP];
  assign stop_on = state.stop_state != cspsb_pkg::ST_RUN;
  assign sleep_on = state.stop_state == cspsb_pkg::ST_SLEEP;

  // ----------------------------------------------------------------
  // Event status for the local interrupt
  // ----------------------------------------------------------------
  // Rising edges of each sideband request are logged
  always_comb begin
    ev_set = '0;
    ev_set[cspsb_pkg::EV_NMI] = next_nmi & ~state.nmi;
    ev_set[cspsb_pkg::EV_SMI] = (|smi_pend) & ~state.smi_prev;
    ev_set[cspsb_pkg::EV_STOP] =
      state.stop_state == cspsb_pkg::ST_RUN && stop_req && !pos_suspend;
    ev_set[cspsb_pkg::EV_SLEEP] =
      state.stop_state == cspsb_pkg::ST_STOP && stop_req && sleep_req
      && !pos_suspend;
    ev_clr = '0;
    if (wr_ev) begin
      ev_clr = reg_req.wdata[cspsb_pkg::EV_W-1:0];
    end
  end

  cspsb_sticky #(
    .W(cspsb_pkg::EV_W)
  ) u_ev_sts (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .set(ev_set),
    .clr(ev_clr),
    .flag(ev_sts)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes, stop sequencer, outputs and read data
  always_comb begin
    next_state = state;
    next_state.nmi = next_nmi;
    next_state.irq = |(ev_sts & state.ev_mask);
    next_state.smi_prev = |smi_pend;
    // Control writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        cspsb_pkg::ADDR_NMI_CTRL: begin
          next_state.nmi_dis = reg_req.wdata[cspsb_pkg::NMI_CHK_DIS:
                                             cspsb_pkg::NMI_SERR_DIS];
        end
        cspsb_pkg::ADDR_NMI_GATE: begin
          next_state.nmi_gate = reg_req.wdata[0];
        end
        cspsb_pkg::ADDR_EV_MASK: begin
          next_state.ev_mask = reg_req.wdata[cspsb_pkg::EV_W-1:0];
        end
        cspsb_pkg::ADDR_SMI_EN: begin
          next_state.smi_en = reg_req.wdata[cspsb_pkg::SMI_HW_W-1:0];
        end
        cspsb_pkg::ADDR_STOP_CTRL: begin
          next_state.stop_ctrl = reg_req.wdata[2:0];
        end
        default: begin
          next_state.nmi_gate = state.nmi_gate;
        end
      endcase
    end
    // Stop sequencer; sleep is dropped before the clock restarts
    case (state.stop_state)
      cspsb_pkg::ST_RUN: begin
        if (stop_req) begin
          next_state.stop_state = cspsb_pkg::ST_STOP;
        end
      end
      cspsb_pkg::ST_STOP: begin
        if (!stop_req) begin
          next_state.stop_state = cspsb_pkg::ST_RUN;
        end else if (sleep_req) begin
          next_state.stop_state = cspsb_pkg::ST_SLEEP;
        end
      end
      cspsb_pkg::ST_SLEEP: begin
        if (!sleep_req) begin
          next_state.stop_state = cspsb_pkg::ST_WAKE;
        end
      end
      cspsb_pkg::ST_WAKE: begin
        next_state.stop_state = cspsb_pkg::ST_STOP;
      end
      default: begin
        next_state.stop_state = cspsb_pkg::ST_RUN;
      end
    endcase
    // Suspend parks the sequencer, the pins float anyway
    if (pos_suspend) begin
      next_state.stop_state = cspsb_pkg::ST_RUN;
    end
    // Read data stands only in the cycle after the strobe
    next_state.rdata = cspsb_pkg::RDATA_RST;
    if (reg_req.rd) begin
      case (reg_req.addr)
        cspsb_pkg::ADDR_NMI_CTRL: begin
          next_state.rdata[3:0] = {state.nmi_dis, nmi_sts};
        end
        cspsb_pkg::ADDR_NMI_GATE: begin
          next_state.rdata[0] = state.nmi_gate;
        end
        cspsb_pkg::ADDR_EV_STATUS: begin
          next_state.rdata[cspsb_pkg::EV_W-1:0] = ev_sts;
        end
        cspsb_pkg::ADDR_EV_MASK: begin
          next_state.rdata[cspsb_pkg::EV_W-1:0] = state.ev_mask;
        end
        cspsb_pkg::ADDR_SMI_EN: begin
          next_state.rdata[cspsb_pkg::SMI_HW_W-1:0] = state.smi_en;
        end
        cspsb_pkg::ADDR_SMI_PEND: begin
          next_state.rdata[cspsb_pkg::SMI_W-1:0] = smi_pend;
        end
        cspsb_pkg::ADDR_STOP_CTRL: begin
          next_state.rdata[2:0] = state.stop_ctrl;
        end
        cspsb_pkg::ADDR_PIN_STATUS: begin
          next_state.rdata[cspsb_pkg::PIN_NMI] = state.nmi;
          next_state.rdata[cspsb_pkg::PIN_SMI] = system_mgmt_interrupt_n_in;
          next_state.rdata[cspsb_pkg::PIN_STOP] =
            cpu_clock_stop_request_n_in;
          next_state.rdata[cspsb_pkg::PIN_SLEEP] = cpu_sleep_request_n_in;
          next_state.rdata[cspsb_pkg::PIN_STATE+1:cspsb_pkg::PIN_STATE] =
            state.stop_state;
        end
        default: begin
          next_state.rdata = cspsb_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Gate starts closed so nmi stays low until software opens it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{
        nmi_dis: cspsb_pkg::NMI_DIS_RST,
        nmi_gate: cspsb_pkg::NMI_GATE_RST,
        ev_mask: cspsb_pkg::EV_MASK_RST,
        smi_en: cspsb_pkg::SMI_EN_RST,
        stop_ctrl: cspsb_pkg::STOP_CTRL_RST,
        stop_state: cspsb_pkg::ST_RUN,
        nmi: 1'b0,
        irq: 1'b0,
        smi_prev: 1'b0,
        rdata: cspsb_pkg::RDATA_RST
      };
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain sideband pins
  // ----------------------------------------------------------------
  // Any pending event pulls the management interrupt low
  cspsb_od_pin u_smi_pin (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .assert_req(|smi_pend),
    .hold_off(pos_suspend),
    .pin(system_mgmt_interrupt_n)
  );

  // Clock stop follows the sequencer, one clock late
  cspsb_od_pin u_stop_pin (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .assert_req(stop_on),
    .hold_off(pos_suspend),
    .pin(cpu_clock_stop_request_n)
  );

  // Sleep follows the sequencer only in its deepest state
  cspsb_od_pin u_sleep_pin (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .assert_req(sleep_on),
    .hold_off(pos_suspend),
    .pin(cpu_sleep_request_n)
  );

  assign nmi = state.nmi;
  assign irq = state.irq;
  assign reg_rdata = state.rdata;

endmodule

`default_nettype wire

// file: tb/cspsb_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module cspsb_host_model (
  // Clock
  input wire logic ref_clk,
  // Sideband pins from the bridge
  input wire logic nmi,
  input wire cspsb_pkg::cspsb_od_type smi_pin,
  input wire cspsb_pkg::cspsb_od_type stop_pin,
  input wire cspsb_pkg::cspsb_od_type sleep_pin,
  // Wire levels seen by the core
  output logic smi_lvl,
  output logic stop_lvl,
  output logic sleep_lvl,
  // What the core takes
  output int nmi_seen,
  output logic serve_nmi,
  output logic serve_smi
);
  logic nmi_q;

  // Pull-ups win while nobody pulls a wire low
  assign smi_lvl = smi_pin.oe_n ? 1'b1 : smi_pin.level;
  assign stop_lvl = stop_pin.oe_n ? 1'b1 : stop_pin.level;
  assign sleep_lvl = sleep_pin.oe_n ? 1'b1 : sleep_pin.level;

  // Management interrupt outranks a pending nmi
  assign serve_smi = !smi_lvl;
  assign serve_nmi = nmi && smi_lvl;

  // A held high level is not a new request, only a rising edge is
  initial begin
    nmi_q = 1'b0;
    nmi_seen = 0;
  end
  always @(posedge ref_clk) begin
    nmi_q <= nmi;
    if (nmi && !nmi_q) begin
      nmi_seen <= nmi_seen + 1;
    end
  end
endmodule

`default_nettype wire

// file: tb/cspsb_top_chk.sv
`timescale 1ns/100ps
`default_nettype none

module cspsb_top_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Block inputs
  input wire cspsb_pkg::cspsb_req_type reg_req,
  input wire logic pci_serr_n,
  input wire logic isa_chk_n,
  input wire logic pos_suspend,
  // Sideband outputs
  input wire logic nmi,
  input wire cspsb_pkg::cspsb_od_type system_mgmt_interrupt_n,
  input wire cspsb_pkg::cspsb_od_type cpu_clock_stop_request_n,
  input wire cspsb_pkg::cspsb_od_type cpu_sleep_request_n
);
  logic nmi_gate, ctrl_wr, open_ok;
  logic [1:0] nmi_dis;

  // Write decode and the nmi path being open
  assign ctrl_wr = reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_NMI_CTRL;
  assign open_ok = !nmi_gate && !pos_suspend;

  // Shadow of gate and disable bits, so checks know when nmi may rise
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_gate <= 1'b1;
      nmi_dis <= 2'h0;
    end else begin
      if (reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_NMI_GATE) begin
        nmi_gate <= reg_req.wdata[0];
      end
      if (ctrl_wr) begin
        nmi_dis <= reg_req.wdata[3:2];
      end
    end
  end

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  // Source taken, then the path stays open for the output stage
  sequence serr_go;
    (!pci_serr_n && !nmi_dis[0] && open_ok) ##1 (open_ok && !nmi_dis[0]);
  endsequence
  sequence chk_go;
    (!isa_chk_n && !nmi_dis[1] && open_ok) ##1 (open_ok && !nmi_dis[1]);
  endsequence

  chk_serr_raise: assert property (serr_go |=> nmi)
    else $error("nmi missed a system error");
  chk_chan_raise: assert property (chk_go |=> nmi)
    else $error("nmi missed a channel check");
  chk_gate_shut: assert property (nmi_gate |=> !nmi)
    else $error("nmi high with the gate shut");
  chk_dis_clears: assert property (
    ctrl_wr && reg_req.wdata[3:2] == 2'b11 |-> ##3 !nmi)
    else $error("nmi still high after disable");
  chk_w1c_drops: assert property (
    ctrl_wr && reg_req.wdata[1:0] == 2'b11 && pci_serr_n && isa_chk_n
    |-> ##2 !nmi)
    else $error("nmi still high after status clear");
  chk_nmi_hold: assert property (
    !ctrl_wr ##1 (nmi && !ctrl_wr && open_ok) |=> nmi)
    else $error("nmi dropped without a clear");
  chk_susp_float: assert property (
    pos_suspend |=> !nmi && system_mgmt_interrupt_n.oe_n
    && cpu_clock_stop_request_n.oe_n && cpu_sleep_request_n.oe_n)
    else $error("pins active during suspend");
  chk_rel_idle: assert property (
    $rose(arst_n) |-> !nmi && system_mgmt_interrupt_n.oe_n
    && cpu_clock_stop_request_n.oe_n && cpu_sleep_request_n.oe_n)
    else $error("pins active after reset");
  chk_sleep_stop: assert property (
    !cpu_sleep_request_n.oe_n |-> !cpu_clock_stop_request_n.oe_n)
    else $error("sleep asserted without clock stop");
  chk_smi_soft: assert property (
    reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_SMI_SW && reg_req.wdata[0]
    |-> ##[1:3] (!system_mgmt_interrupt_n.oe_n || pos_suspend))
    else $error("software smi not driven");
  chk_stop_soft: assert property (
    reg_req.wr && reg_req.addr == cspsb_pkg::ADDR_STOP_CTRL
    && reg_req.wdata[0] |-> ##[1:4]
    (!cpu_clock_stop_request_n.oe_n || pos_suspend))
    else $error("software clock stop not driven");
endmodule

bind cspsb_top cspsb_top_chk chk_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req),
  .pci_serr_n(pci_serr_n), .isa_chk_n(isa_chk_n),
  .pos_suspend(pos_suspend), .nmi(nmi),
  .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
  .cpu_clock_stop_request_n(cpu_clock_stop_request_n),
  .cpu_sleep_request_n(cpu_sleep_request_n)
);

`default_nettype wire

// file: tb/test_cpu_sideband_nmi_smi_stop.sv
`timescale 1ns/100ps
`default_nettype none

module test_cpu_sideband_nmi_smi_stop;
  logic ref_clk, arst_n, pci_serr_n, isa_chk_n, stop_event, pos_suspend;
  logic nmi, irq, smi_lvl, stop_lvl, sleep_lvl, serve_nmi, serve_smi;
  logic [2:0] smi_event;
  logic [3:0] pins;
  logic [31:0] reg_rdata;
  logic [1:0] src, dis;
  cspsb_pkg::cspsb_req_type reg_req;
  cspsb_pkg::cspsb_od_type smi_pin, stop_pin, sleep_pin;
  int nmi_seen, err_total, cmp_count, nmi_want;

  assign pins = {nmi, smi_pin.oe_n, stop_pin.oe_n, sleep_pin.oe_n};

  cspsb_top dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .pci_serr_n(pci_serr_n), .isa_chk_n(isa_chk_n),
    .smi_event(smi_event), .stop_event(stop_event),
    .pos_suspend(pos_suspend), .nmi(nmi),
    .system_mgmt_interrupt_n_in(smi_lvl), .system_mgmt_interrupt_n(smi_pin),
    .cpu_clock_stop_request_n_in(stop_lvl),
    .cpu_clock_stop_request_n(stop_pin),
    .cpu_sleep_request_n_in(sleep_lvl), .cpu_sleep_request_n(sleep_pin),
    .irq(irq)
  );

  cspsb_host_model host (
    .ref_clk(ref_clk), .nmi(nmi), .smi_pin(smi_pin), .stop_pin(stop_pin),
    .sleep_pin(sleep_pin), .smi_lvl(smi_lvl), .stop_lvl(stop_lvl),
    .sleep_lvl(sleep_lvl), .nmi_seen(nmi_seen), .serve_nmi(serve_nmi),
    .serve_smi(serve_smi)
  );

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Expected control word: disables read back, disabled status stays 0
  function automatic logic [31:0] ctrl_exp(input logic [1:0] s, d);
    return {28'h000_0000, d, s & ~d};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog at 50000 cycles: the whole sequence needs well under 5000 cycles
  initial begin
    #250_000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    err_total = 0;
    cmp_count = 0;
    nmi_want = 1;
    arst_n = 1'b0;
    reg_req = '0;
    {pci_serr_n, isa_chk_n, stop_event, pos_suspend} = 4'b1100;
    smi_event = 3'h0;
    void'($urandom(93332));
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(1);
    check(pins, 4'h7);
    rd(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_0000);
    rd(cspsb_pkg::ADDR_NMI_GATE, 32'h0000_0001);
    // Read data stand one cycle only, then fall back to zero
    cyc(1);
    check(reg_rdata, 32'h0000_0000);
    rd(cspsb_pkg::ADDR_PIN_STATUS, 32'h0000_000E);
    rd(8'hFC, 32'h0000_0000);
    // Gate shut: status latches but nmi stays low until the gate opens
    @(posedge ref_clk);
    pci_serr_n <= 1'b0;
    cyc(4);
    check(nmi, 1'b0);
    rd(cspsb_pkg::ADDR_NMI_CTRL, ctrl_exp(2'b01, 2'b00));
    wr(cspsb_pkg::ADDR_NMI_GATE, 32'h0000_0000);
    cyc(3);
    check(nmi, 1'b1);
    // Clear while the source is still low: the set wins
    wr(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_0001);
    cyc(3);
    check(nmi, 1'b1);
    @(posedge ref_clk);
    pci_serr_n <= 1'b1;
    wr(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_0001);
    cyc(3);
    check(nmi, 1'b0);
    // Random sources against random disables
    for (int i = 0; i < 24; i++) begin
      src = 2'($urandom_range(3));
      dis = 2'($urandom_range(3));
      wr(cspsb_pkg::ADDR_NMI_CTRL, {28'h000_0000, dis, 2'b11});
      @(posedge ref_clk);
      {isa_chk_n, pci_serr_n} <= ~src;
      cyc(4);
      check(nmi, |(src & ~dis));
      rd(cspsb_pkg::ADDR_NMI_CTRL, ctrl_exp(src, dis));
      wr(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_000C);
      cyc(4);
      check(nmi, 1'b0);
      @(posedge ref_clk);
      {isa_chk_n, pci_serr_n} <= 2'b11;
      nmi_want += int'(|(src & ~dis));
    end
    check(nmi_seen, nmi_want);
    wr(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_0003);
    // Local interrupt: raise, mask, clear
    wr(cspsb_pkg::ADDR_EV_MASK, 32'h0000_000F);
    cyc(3);
    check(irq, 1'b1);
    wr(cspsb_pkg::ADDR_EV_MASK, 32'h0000_0000);
    cyc(3);
    check(irq, 1'b0);
    wr(cspsb_pkg::ADDR_EV_STATUS, 32'h0000_000F);
    rd(cspsb_pkg::ADDR_EV_STATUS, 32'h0000_0000);
    wr(cspsb_pkg::ADDR_EV_MASK, 32'h0000_000F);
    // Hardware management events
    wr(cspsb_pkg::ADDR_SMI_EN, 32'h0000_0007);
    @(posedge ref_clk);
    smi_event <= 3'($urandom_range(7, 1));
    cyc(4);
    check(pins, 4'b0011);
    check(irq, 1'b1);
    @(posedge ref_clk);
    smi_event <= 3'h0;
    wr(cspsb_pkg::ADDR_SMI_PEND, 32'h0000_000F);
    cyc(3);
    check(pins, 4'b0111);
    // Software management request beside a pending nmi
    @(posedge ref_clk);
    pci_serr_n <= 1'b0;
    wr(cspsb_pkg::ADDR_SMI_SW, 32'h0000_0001);
    cyc(4);
    check({serve_smi, serve_nmi}, 2'b10);
    wr(cspsb_pkg::ADDR_STOP_CTRL, 32'h0000_0003);
    cyc(6);
    check(pins, 4'b1000);
    // Sequencer parked in sleep; every event logged since the last clear
    rd(cspsb_pkg::ADDR_PIN_STATUS, 32'h0000_0031);
    rd(cspsb_pkg::ADDR_EV_STATUS, 32'h0000_000F);
    rd(cspsb_pkg::ADDR_SMI_PEND, 32'h0000_0008);
    rd(cspsb_pkg::ADDR_SMI_EN, 32'h0000_0007);
    rd(cspsb_pkg::ADDR_STOP_CTRL, 32'h0000_0003);
    rd(cspsb_pkg::ADDR_EV_MASK, 32'h0000_000F);
    check(irq, 1'b1);
    // Suspend floats everything and drops nmi
    @(posedge ref_clk);
    pos_suspend <= 1'b1;
    cyc(3);
    check(pins, 4'b0111);
    @(posedge ref_clk);
    {pos_suspend, pci_serr_n} <= 2'b01;
    wr(cspsb_pkg::ADDR_SMI_PEND, 32'h0000_000F);
    wr(cspsb_pkg::ADDR_NMI_CTRL, 32'h0000_0003);
    wr(cspsb_pkg::ADDR_STOP_CTRL, 32'h0000_0000);
    cyc(8);
    check(pins, 4'b0111);
    // Hardware clock-stop request
    wr(cspsb_pkg::ADDR_STOP_CTRL, 32'h0000_0004);
    @(posedge ref_clk);
    stop_event <= 1'b1;
    cyc(4);
    check(pins, 4'b0101);
    @(posedge ref_clk);
    stop_event <= 1'b0;
    cyc(6);
    check(pins, 4'b0111);
    tally_and_finish;
  end
endmodule

`default_nettype wire
